/* File: include/dtm_pkg.sv */
// constants, types and helpers shared by the date/time command mailbox
// assumes a single 40 MHz clock and a same-clock register port
//
// Contract
// - first request word 768 selects the read date and time command
// - status shows 0x0003 while busy; master polls until it changes
// - executed command code is shown; master restarts on mismatch
// - status low byte holds error code, zero means success
// - too many parameters gives error code 15, status 0x030f
// - successful read sets reply length register to 8
// - reply word one: month high byte, day low byte
// - reply word two: year offset from 2000 high, hour low
// - reply word three: minutes high byte, seconds low byte
// - reply word four: full 16-bit millisecond count
// - every event is stamped with the current date and time
// - a supplied date and time becomes the current time
// - current time is broadcast to all attached modules
// - synchronized only if last sync lies within 2 hours
// - frame address is register number minus one
package dtm_pkg;
  // clock and timing
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_MS = 1;
  localparam int CYC_PER_TICK = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int SYNC_WINDOW_H = 2;
  localparam int S_PER_H = 3600;
  localparam int SYNC_WINDOW_MS = SYNC_WINDOW_H * S_PER_H * MS_PER_S;

  // register numbers (frame address plus one)
  localparam logic [15:0] ADDR_TO_REG = 16'h0001;
  localparam logic [15:0] REG_REQ_BASE = 16'h1f40;
  localparam int REQ_WORDS = 20;
  localparam logic [15:0] REG_REQ_LAST = 16'h1f53;
  localparam logic [15:0] REG_EXEC_CODE = 16'h1f54;
  localparam logic [15:0] REG_STATUS = 16'h1f55;
  localparam logic [15:0] REG_REPLY_LEN = 16'h1f56;
  localparam logic [15:0] REG_MONTH_DAY = 16'h1f57;
  localparam logic [15:0] REG_YEAR_HOUR = 16'h1f58;
  localparam logic [15:0] REG_MIN_SEC = 16'h1f59;
  localparam logic [15:0] REG_MILLI = 16'h1f5a;

  // request word indices
  localparam logic [4:0] IDX_CMD = 5'h00;
  localparam logic [4:0] IDX_LEN = 5'h01;

  // command, status and error values
  localparam logic [15:0] CMD_READ_DT = 16'h0300;
  localparam logic [15:0] FIXED_LEN = 16'h000a;
  localparam logic [15:0] REPLY_LEN_DT = 16'h0008;
  localparam logic [15:0] LEN_NONE = 16'h0000;
  localparam logic [15:0] STATUS_BUSY = 16'h0003;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [7:0] STATUS_DONE_HI = 8'h03;
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_RANGE = 8'h0f;
  localparam logic [7:0] ERR_BAD_CMD = 8'h0e;

  // calendar limits; year offset counts from 2000
  localparam int YEAR_BASE = 2000;
  localparam logic [15:0] MSEC_MAX = 16'h03e7;
  localparam logic [7:0] SEC_MAX = 8'h3b;
  localparam logic [7:0] MIN_MAX = 8'h3b;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] MON_MAX = 8'h0c;
  localparam logic [7:0] FIRST = 8'h01;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [63:0] TIME_RESET = 64'h0101_0000_0000_0000;

  // packed time: mon, day, year, hour, min, sec, msec
  localparam int T_MON = 56;
  localparam int T_DAY = 48;
  localparam int T_YEAR = 40;
  localparam int T_HOUR = 32;
  localparam int T_MIN = 24;
  localparam int T_SEC = 16;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_RD_CMD = 6'b000010,
    ST_RD_LEN = 6'b000100,
    ST_CHECK  = 6'b001000,
    ST_LOAD   = 6'b010000,
    ST_DONE   = 6'b100000
  } dtm_state_t;

  // last day of a month; years divisible by four are leap years
  function automatic logic [7:0] dtm_month_days(input logic [7:0] mon,
                                                input logic [7:0] year);
    case (mon)
      8'h02: dtm_month_days = (year[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: dtm_month_days = 8'h1e;
      default: dtm_month_days = 8'h1f;
    endcase
  endfunction : dtm_month_days

  // frame address to register number
  function automatic logic [15:0] dtm_reg_num(input logic [15:0] addr);
    dtm_reg_num = addr + ADDR_TO_REG;
  endfunction : dtm_reg_num
endpackage : dtm_pkg

/* File: hdl/dtm_req_mem.sv */
// storage for the 20-word command request block
// assumes one write and one read per cycle, read data one cycle later
`timescale 1ns/1ps
module dtm_req_mem
  import dtm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write side
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [15:0] wdata,
  // read side
  input wire logic [4:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [REQ_WORDS];

  // array has no reset; master always writes the whole block first
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : dtm_req_mem

/* File: hdl/dtm_mailbox.sv */
// date/time command mailbox with time-of-day keeper
// assumes register port and time/event inputs run on clk
`timescale 1ns/1ps
module dtm_mailbox
  import dtm_pkg::*;
#(
  parameter int CYC_PER_MS = CYC_PER_TICK,
  parameter int SYNC_MS = SYNC_WINDOW_MS
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port, frame addressing
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // external time setting
  input wire logic time_set,
  input wire logic [63:0] time_set_value,
  output logic ext_synced,
  // event stamping
  input wire logic event_req,
  output logic stamp_valid,
  output logic [63:0] stamp_time,
  // broadcast to attached modules
  output logic bcast_valid,
  output logic [63:0] bcast_time
);
  dtm_state_t state;
  logic [15:0] wr_reg;
  logic [15:0] rd_reg;
  logic req_hit;
  logic start;
  logic [4:0] mem_waddr;
  logic [4:0] mem_raddr;
  logic [15:0] mem_rdata;
  logic [15:0] cmd_q;
  logic [7:0] err_q;
  logic [15:0] exec_code;
  logic [15:0] status;
  logic [15:0] reply_len;
  logic [63:0] reply_time;
  logic [63:0] now;
  logic [31:0] tick_cnt;
  logic tick;
  logic [31:0] sync_age;
  logic bcast_req;
  logic sec_wrap;
  logic min_step;
  logic hour_step;
  logic day_step;
  logic mon_step;
  logic year_step;
  logic [15:0] next_rdata;

  // error code for a request: command first, then its length
  function automatic logic [7:0] judge_request(input logic [15:0] cmd,
                                               input logic [15:0] len);
    if (cmd != CMD_READ_DT) begin
      judge_request = ERR_BAD_CMD;
    end else if (len > FIXED_LEN) begin
      judge_request = ERR_RANGE;
    end else begin
      judge_request = ERR_OK;
    end
  endfunction : judge_request

  // one reply word out of the packed time, picked by register number
  function automatic logic [15:0] reply_word(input logic [63:0] v,
                                             input logic [15:0] rn);
    case (rn)
      REG_MONTH_DAY: reply_word = v[T_DAY+:16];
      REG_YEAR_HOUR: reply_word = v[T_HOUR+:16];
      REG_MIN_SEC: reply_word = v[T_SEC+:16];
      default: reply_word = v[15:0];
    endcase
  endfunction : reply_word

  // address decode on register numbers
  // read and write share one address bus, so both decode alike
  assign wr_reg = dtm_reg_num(reg_addr);
  assign rd_reg = dtm_reg_num(reg_addr);
  assign req_hit = reg_wr && (wr_reg >= REG_REQ_BASE)
                   && (wr_reg <= REG_REQ_LAST);
  // block writes while busy are dropped so a running command stays intact
  assign start = req_hit && (wr_reg == REG_REQ_LAST)
                 && (state == ST_IDLE);
  assign mem_waddr = 5'(wr_reg - REG_REQ_BASE);
  assign mem_raddr = (state == ST_RD_CMD) ? IDX_CMD : IDX_LEN;

  // request words live in a small memory; only command and length are
  // read back, so the sequencer spends two cycles fetching them
  dtm_req_mem u_req_mem (
    .clk(clk),
    .rst(rst),
    .we(req_hit && (state == ST_IDLE)),
    .waddr(mem_waddr),
    .wdata(reg_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // command sequencer
  // fixed five-cycle walk; the busy status covers all of it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (start) state <= ST_RD_CMD;
        ST_RD_CMD: state <= ST_RD_LEN;
        ST_RD_LEN: state <= ST_CHECK;
        ST_CHECK: state <= ST_LOAD;
        ST_LOAD: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // decode command word, then judge the length word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= 16'h0000;
      err_q <= ERR_OK;
    end else if (state == ST_RD_LEN) begin
      cmd_q <= mem_rdata;
    end else if (state == ST_CHECK) begin
      err_q <= judge_request(cmd_q, mem_rdata);
    end
  end

  // reply buffer, filled before the status leaves busy
  // a failed command keeps the old reply words; the zero length register
  // and the error code in the status tell the master that they are stale
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_code <= 16'h0000;
      reply_len <= LEN_NONE;
      reply_time <= 64'h0000_0000_0000_0000;
    end else if (state == ST_LOAD) begin
      exec_code <= cmd_q;
      if (err_q == ERR_OK) begin
        reply_len <= REPLY_LEN_DT;
        reply_time <= now;
      end else begin
        reply_len <= LEN_NONE;
      end
    end
  end

  // status: busy from the last block write until the buffer is done
  // the final code lands a cycle after the buffer, so a poller that
  // sees it may read the reply words at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= STATUS_RESET;
    end else if (start) begin
      status <= STATUS_BUSY;
    end else if (state == ST_DONE) begin
      status <= {STATUS_DONE_HI, err_q};
    end
  end

  // read multiplexer; request block and unmapped numbers read as zero
  always_comb begin
    case (rd_reg)
      REG_EXEC_CODE: next_rdata = exec_code;
      REG_STATUS: next_rdata = status;
      REG_REPLY_LEN: next_rdata = reply_len;
      REG_MONTH_DAY: next_rdata = reply_word(reply_time, rd_reg);
      REG_YEAR_HOUR: next_rdata = reply_word(reply_time, rd_reg);
      REG_MIN_SEC: next_rdata = reply_word(reply_time, rd_reg);
      REG_MILLI: next_rdata = reply_word(reply_time, rd_reg);
      default: next_rdata = 16'h0000;
    endcase
  end

  // read data register; holds between reads so a slow master can look late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // millisecond tick prescaler; restarts on a time set
  // the restart makes the first ms after a set a full one, at the cost
  // of dropping the part of a ms that had already run
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (time_set || (tick_cnt == 32'(CYC_PER_MS - 1))) begin
      tick_cnt <= 32'h0000_0000;
      tick <= !time_set;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick <= 1'b0;
    end
  end

  // carry chain of the calendar; each stage builds on the one below, and the day wrap also reads the month and year
  assign sec_wrap = tick && (now[15:0] == MSEC_MAX);
  assign min_step = sec_wrap && (now[T_SEC+:8] >= SEC_MAX);
  assign hour_step = min_step && (now[T_MIN+:8] >= MIN_MAX);
  assign day_step = hour_step && (now[T_HOUR+:8] >= HOUR_MAX);
  assign mon_step = day_step
                    && (now[T_DAY+:8] >= dtm_month_days(now[T_MON+:8],
                                                        now[T_YEAR+:8]));
  assign year_step = mon_step && (now[T_MON+:8] >= MON_MAX);

  // calendar counter; a set overrides the running count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      now <= TIME_RESET;
    end else if (time_set) begin
      now <= time_set_value;
    end else if (tick) begin
      now[15:0] <= now[15:0] + 16'h0001;
      if (sec_wrap) begin
        now[15:0] <= 16'h0000;
        now[T_SEC+:8] <= now[T_SEC+:8] + 8'h01;
        if (min_step) begin
          now[T_SEC+:8] <= 8'h00;
          now[T_MIN+:8] <= now[T_MIN+:8] + 8'h01;
          if (hour_step) begin
            now[T_MIN+:8] <= 8'h00;
            now[T_HOUR+:8] <= now[T_HOUR+:8] + 8'h01;
            if (day_step) begin
              now[T_HOUR+:8] <= 8'h00;
              now[T_DAY+:8] <= now[T_DAY+:8] + 8'h01;
              if (mon_step) begin
                now[T_DAY+:8] <= FIRST;
                now[T_MON+:8] <= now[T_MON+:8] + 8'h01;
                if (year_step) begin
                  now[T_MON+:8] <= FIRST;
                  now[T_YEAR+:8] <= now[T_YEAR+:8] + 8'h01;
                end
              end
            end
          end
        end
      end
    end
  end

  // sync age in ms; flag drops once the window has run out
  // no partial ms at the start, since the prescaler restarts on a set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_age <= 32'h0000_0000;
      ext_synced <= 1'b0;
    end else if (time_set) begin
      sync_age <= 32'h0000_0000;
      ext_synced <= 1'b1;
    end else if (tick && ext_synced) begin
      if (sync_age == 32'(SYNC_MS - 1)) begin
        ext_synced <= 1'b0;
      end else begin
        sync_age <= sync_age + 32'h0000_0001;
      end
    end
  end

  // broadcast after every set and every whole second
  // the copy lags the count by a cycle; receivers take it on the pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bcast_req <= 1'b0;
      bcast_valid <= 1'b0;
      bcast_time <= TIME_RESET;
    end else begin
      bcast_req <= time_set || sec_wrap;
      bcast_valid <= bcast_req;
      if (bcast_req) begin
        bcast_time <= now;
      end
    end
  end

  // event stamp taken from the live counter
  // the live count, not the broadcast copy, so an event right after a
  // set already carries the new time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stamp_valid <= 1'b0;
      stamp_time <= 64'h0000_0000_0000_0000;
    end else begin
      stamp_valid <= event_req;
      if (event_req) begin
        stamp_time <= now;
      end
    end
  end
endmodule : dtm_mailbox

/* File: tb/dtm_mailbox_monitor.sv */
// checker for the mailbox register port, stamping and broadcast
// assumes it is bound onto dtm_mailbox, one clock domain
`timescale 1ns/1ps
module dtm_mailbox_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // time, events, broadcast
  input wire logic time_set,
  input wire logic [63:0] time_set_value,
  input wire logic ext_synced,
  input wire logic event_req,
  input wire logic stamp_valid,
  input wire logic [63:0] stamp_time,
  input wire logic bcast_valid,
  input wire logic [63:0] bcast_time
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // command start and a status poll
  sequence s_start;
    reg_wr && reg_addr == 16'h1f52;
  endsequence
  sequence s_poll;
    reg_rd && reg_addr == 16'h1f54;
  endsequence
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  chk_read_quiet: assert property (!reg_rd |=> !reg_rvalid)
    else $error("spurious read answer");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved");
  chk_busy_status: assert property (s_start ##1 s_poll |=>
    reg_rdata == 16'h0003) else $error("busy not shown");
  chk_final_status: assert property (s_start ##7 s_poll |=>
    reg_rdata[15:8] == 8'h03 && reg_rdata != 16'h0003)
    else $error("final status missing");
  chk_stamp_pulse: assert property (event_req |=> stamp_valid)
    else $error("stamp missing");
  chk_stamp_set: assert property (time_set ##1 event_req |=>
    stamp_time == $past(time_set_value, 2)) else $error("stamp wrong");
  chk_sync_rise: assert property (time_set |=> ext_synced[*8])
    else $error("sync flag low");
  chk_bcast_set: assert property (time_set |-> ##2 bcast_valid &&
    bcast_time == $past(time_set_value, 2)) else $error("bcast wrong");
endmodule : dtm_mailbox_monitor

bind dtm_mailbox dtm_mailbox_monitor u_dtm_mailbox_monitor (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .time_set(time_set), .time_set_value(time_set_value),
  .ext_synced(ext_synced), .event_req(event_req),
  .stamp_valid(stamp_valid), .stamp_time(stamp_time),
  .bcast_valid(bcast_valid), .bcast_time(bcast_time));

/* File: tb/dtm_master_model.sv */
// master model: block write of a request, then status polling
// assumes the mailbox port on the same clock, 1 ns drive skew
`timescale 1ns/1ps
module dtm_master_model (
  // clock
  input wire logic clk,
  // register port towards the mailbox
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // one read; frame address is the register number minus one
  task automatic rd(input logic [15:0] rn, output logic [15:0] d,
                    output logic ok);
    reg_addr = rn - 16'h0001;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr; // inverted, so no stale number
    d = reg_rdata;
    ok = reg_rvalid;
    @(posedge clk);
    #1;
  endtask : rd
  // whole request in one burst, then poll until not busy
  task automatic cmd(input logic [15:0] code, input logic [15:0] len,
                     output logic [15:0] st);
    logic [15:0] w [20];
    logic ok;
    w = '{default: 16'h0000};
    w[0] = code;
    w[1] = len;
    w[2] = 16'h1501;
    w[17] = 16'h1f53;
    w[18] = 16'h1f54;
    w[19] = 16'h1f55;
    reg_wr = 1'b1;
    for (int i = 0; i < 20; i++) begin
      reg_addr = 16'h1f3f + i[15:0];
      reg_wdata = w[i];
      @(posedge clk);
      #1;
    end
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
    st = 16'h0003;
    // bounded poll; a stuck busy shows up as a wrong status
    for (int n = 0; n < 20 && st === 16'h0003; n++) begin
      rd(16'h1f55, st, ok);
    end
  endtask : cmd
endmodule : dtm_master_model

/* File: tb/dtm_mailbox_test.sv */
// self-checking bench for the date/time command mailbox
// assumes the master model owns the register port
`timescale 1ns/1ps
module dtm_mailbox_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, d, code, len, st;
  logic reg_wr, reg_rd, reg_rvalid, ext_synced, stamp_valid, bcast_valid;
  logic ok;
  logic time_set = 1'b0;
  logic event_req = 1'b0;
  logic [63:0] time_set_value = 64'h0;
  logic [63:0] stamp_time, bcast_time, t;
  logic [15:0] lfsr = 16'h0f70;
  int num_errors = 0;
  int check_count = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  dtm_mailbox #(.CYC_PER_MS(100), .SYNC_MS(3)) u_dtm_mailbox (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .time_set(time_set),
    .time_set_value(time_set_value), .ext_synced(ext_synced),
    .event_req(event_req), .stamp_valid(stamp_valid),
    .stamp_time(stamp_time), .bcast_valid(bcast_valid),
    .bcast_time(bcast_time));
  dtm_master_model u_dtm_master_model (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    next_rand = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : next_rand
  function automatic logic [15:0] exp_word(input logic [63:0] v,
                                           input int j);
    exp_word = v[63-16*j -: 16];
  endfunction : exp_word
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic set_time(input logic [63:0] v);
    time_set_value = v;
    time_set = 1'b1;
    step();
    time_set = 1'b0;
  endtask : set_time
  // main sequence; ms ticks are slow so a command sees a still time
  initial begin
    repeat (8) step();
    rst = 1'b0;
    check(bcast_time, 64'h0101_0000_0000_0000);
    check(ext_synced, 64'h0);
    u_dtm_master_model.rd(16'h1f60, d, ok);
    check({ok, d}, 17'h10000);
    for (int k = 0; k < 6; k++) begin
      lfsr = next_rand(lfsr);
      t = {{5'h0, lfsr[2:0]} + 8'h01, {4'h0, lfsr[6:3]} + 8'h01,
           lfsr[15:8], {4'h0, lfsr[11:8]}, {3'h0, lfsr[12:8]},
           {3'h0, lfsr[4:0]}, {7'h0, lfsr[8:0]}};
      set_time(t);
      event_req = 1'b1;
      step();
      event_req = 1'b0;
      check(stamp_valid, 64'h1);
      check(stamp_time, t);
      check(bcast_valid, 64'h1);
      check(bcast_time, t);
      step();
      check(ext_synced, 64'h1);
      len = k == 0 ? 16'h000a : k == 1 ? 16'h000b : {12'h0, lfsr[15:12]};
      code = k == 2 ? 16'h0301 : 16'h0300;
      st = code != 16'h0300 ? 16'h030e : len > 16'h000a ? 16'h030f : 16'h0300;
      u_dtm_master_model.cmd(code, len, d);
      check(d, st);
      u_dtm_master_model.rd(16'h1f54, d, ok);
      check(d, code);
      u_dtm_master_model.rd(16'h1f56, d, ok);
      check(d, st == 16'h0300 ? 16'h0008 : 16'h0000);
      for (int j = 0; j < 4 && st == 16'h0300; j++) begin
        u_dtm_master_model.rd(16'h1f57 + j[15:0], d, ok);
        check(d, exp_word(t, j));
      end
    end
    // leap-day rollover on the first ms tick, then sync expiry
    set_time(64'h021c_0417_3b3b_03e7);
    repeat (3) step();
    for (int n = 0; n < 200 && bcast_valid !== 1'b1; n++) step();
    if (bcast_valid !== 1'b1) begin
      num_errors++;
    end else begin
      check(bcast_time, 64'h021d_0400_0000_0000);
      repeat (180) step();
      check(ext_synced, 64'h1);
      repeat (40) step();
      check(ext_synced, 64'h0);
    end
    end_sim();
  end
endmodule : dtm_mailbox_test
